// file: design/debug_breakpoint_status_regs.sv
// Purpose: Processor status and debug register bank of one tile
// Assumes: debug_mode and probes come from core logic on clk
// Notes:   Ring counts come from oscillators outside the clk domain
// What this block does
// - Three ring counts read as 16 bits, upper bits zero.
// - Ring counts are never cleared by system reset.
// - Memory size register reads bytes in bits 31:2, low bits zero.
// - Debug entry captures status flags in bits 4:0, 31:11 zero.
// - Status also holds bits 10,9,8 (read only),7,6.
// - Debug entry captures saved program counter, full 32 bits.
// - Debug entry captures saved stack pointer, full 32 bits.
// - Register-get thread operand is 8 bits, rest reads zero.
// - Register-get register operand is 5 bits, rest reads zero.
// - Cause field 3 bits, reset 0, codes 1 to 5.
// - Breakpoint index 2 bits, lowest wins, zero for host and call.
// - Thread field 8 bits, zero for host request.
// - Data watch stores address, resource watch stores identifier.
// - Eight-bit halt vector keeps marked threads stopped after return.
// - Eight scratch words, shared with tile configuration port.
// - Four code breakpoints raise request on program counter match outside debug mode.
// - Control bit 0 enables breakpoint, reset 0.
// - Control bit 1 inverts match to inequality, reset 0.
// - Control bits 23:16 enable per thread, reset 0.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module debug_breakpoint_status_regs #(
    parameter logic [31:0] MEM_SIZE_BYTES = 32'h0004_0000
) (
    input  wire logic                            clk,
    input  wire logic                            rst_n,
    input  wire debug_status_pkg::reg_req_t      reg_req,
    output logic [31:0]                          rd_data,
    input  wire logic                            debug_mode,
    input  wire debug_status_pkg::debug_entry_t  entry,
    input  wire debug_status_pkg::pc_probe_t     probe,
    input  wire logic [15:0]                     wire_ring_in,
    input  wire logic [15:0]                     periph_cell_ring_in,
    input  wire logic [15:0]                     periph_wire_ring_in,
    input  wire logic [2:0]                      cfg_index,
    input  wire logic [31:0]                     cfg_wdata,
    input  wire logic                            cfg_write,
    output logic [31:0]                          cfg_rdata,
    output logic                                 break_request,
    output logic [1:0]                           break_index,
    output logic [7:0]                           break_thread,
    output logic [7:0]                           halted_threads,
    output logic [7:0]                           target_thread_field,
    output logic [4:0]                           target_register_field
);

    // ========================================================
    // Storage
    logic [15:0] ring_meta [3];
    logic [15:0] ring_count_value [3];
    logic [31:0] saved_status_word;
    logic [31:0] saved_program_counter;
    logic [31:0] saved_stack_pointer;
    logic [31:0] debug_entry_cause;
    logic [31:0] debug_entry_info;
    logic [31:0] debugger_scratch [8];
    logic [31:0] code_break_address [4];
    logic [31:0] code_break_control [4];
    logic [3:0]  hit;
    logic        any_hit;
    logic [1:0]  lowest_hit;
    logic        wr_ok;
    logic [31:0] next_rd_data;
    logic [7:0]  a;
    logic [31:0] wd;

    assign a     = reg_req.addr;
    assign wd    = reg_req.wdata;
    assign wr_ok = reg_req.write && debug_mode;

    // ========================================================
    // Ring counts: two stages, no reset so values survive it
    always_ff @(posedge clk) begin
        ring_meta[0]        <= wire_ring_in;
        ring_meta[1]        <= periph_cell_ring_in;
        ring_meta[2]        <= periph_wire_ring_in;
        ring_count_value[0] <= ring_meta[0];
        ring_count_value[1] <= ring_meta[1];
        ring_count_value[2] <= ring_meta[2];
    end

    // ========================================================
    // Saved context: entry capture beats a software write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            saved_status_word     <= debug_status_pkg::RESET_WORD;
            saved_program_counter <= debug_status_pkg::RESET_WORD;
            saved_stack_pointer   <= debug_status_pkg::RESET_WORD;
        end else if (entry.valid) begin
            saved_status_word <= entry.status
                & debug_status_pkg::STATUS_KEEP_MASK;
            saved_program_counter <= entry.pc;
            saved_stack_pointer   <= entry.sp;
        end else if (wr_ok) begin
            unique case (a)
                debug_status_pkg::SAVED_STATUS_WORD_IDX: begin
                    saved_status_word <=
                        (wd & debug_status_pkg::STATUS_WRITE_MASK)
                        | (saved_status_word
                           & ~debug_status_pkg::STATUS_WRITE_MASK);
                end
                debug_status_pkg::SAVED_PROGRAM_COUNTER_IDX: begin
                    saved_program_counter <= wd;
                end
                debug_status_pkg::SAVED_STACK_POINTER_IDX: begin
                    saved_stack_pointer <= wd;
                end
                default: begin
                end
            endcase
        end
    end

    // ========================================================
    // Entry cause, thread, index and data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            debug_entry_cause <= debug_status_pkg::RESET_WORD;
            debug_entry_info  <= debug_status_pkg::RESET_WORD;
        end else if (entry.valid) begin
            debug_entry_cause <= debug_status_pkg::RESET_WORD;
            debug_entry_cause[debug_status_pkg::CAUSE_LSB +: 3] <=
                entry.cause;
            if (entry.cause != debug_status_pkg::CAUSE_HOST) begin
                debug_entry_cause[debug_status_pkg::CAUSE_THREAD_LSB +: 8]
                    <= entry.thread;
            end
            if (entry.cause != debug_status_pkg::CAUSE_HOST
                && entry.cause != debug_status_pkg::CAUSE_CALL) begin
                debug_entry_cause[debug_status_pkg::CAUSE_INDEX_LSB +: 2]
                    <= entry.index;
            end
            if (entry.cause == debug_status_pkg::CAUSE_DATA_WCH
                || entry.cause == debug_status_pkg::CAUSE_RSRC_WCH) begin
                debug_entry_info <= entry.info;
            end
        end else if (wr_ok) begin
            if (a == debug_status_pkg::DEBUG_ENTRY_CAUSE_IDX) begin
                debug_entry_cause <= wd
                    & debug_status_pkg::ENTRY_CAUSE_MASK;
            end
            if (a == debug_status_pkg::DEBUG_ENTRY_INFO_IDX) begin
                debug_entry_info <= wd;
            end
        end
    end

    // ========================================================
    // Register-get operands and halt vector
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            target_thread_field   <= '0;
            target_register_field <= '0;
            halted_threads        <= '0;
        end else if (wr_ok) begin
            if (a == debug_status_pkg::REG_GET_THREAD_OPERAND_IDX) begin
                target_thread_field <= wd[7:0];
            end
            if (a == debug_status_pkg::REG_GET_INDEX_OPERAND_IDX) begin
                target_register_field <= wd[4:0];
            end
            if (a == debug_status_pkg::THREAD_HALT_VECTOR_IDX) begin
                halted_threads <= wd[7:0];
            end
        end
    end

    // ========================================================
    // Scratch words, shared with configuration port
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < debug_status_pkg::SCRATCH_N; i++) begin
                debugger_scratch[i] <= debug_status_pkg::RESET_WORD;
            end
        end else if (wr_ok && a[7:3]
                     == debug_status_pkg::DEBUGGER_SCRATCH_IDX[7:3]) begin
            debugger_scratch[a[2:0]] <= wd;
        end else if (cfg_write) begin
            debugger_scratch[cfg_index] <= cfg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_rdata <= debug_status_pkg::RESET_WORD;
        end else begin
            cfg_rdata <= debugger_scratch[cfg_index];
        end
    end

    // ========================================================
    // Code breakpoints
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < debug_status_pkg::BREAK_N; i++) begin
                code_break_address[i] <= debug_status_pkg::RESET_WORD;
                code_break_control[i] <=
                    debug_status_pkg::RESET_WORD;
            end
        end else if (wr_ok) begin
            if (a[7:2] == debug_status_pkg::CODE_BREAK_ADDRESS_IDX[7:2]) begin
                code_break_address[a[1:0]] <= wd;
            end
            if (a[7:2] == debug_status_pkg::CODE_BREAK_CONTROL_IDX[7:2]) begin
                code_break_control[a[1:0]] <= wd
                    & debug_status_pkg::BREAK_CONTROL_MASK;
            end
        end
    end

    for (genvar g = 0; g < debug_status_pkg::BREAK_N; g++) begin : g_brk
        logic [7:0] per_thread_break_enables;
        logic       break_on;
        logic       same;
        logic       invert;
        assign per_thread_break_enables = code_break_control[g][
            debug_status_pkg::BREAK_THREAD_LSB +: 8];
        assign break_on = code_break_control[g][debug_status_pkg::BREAK_ON];
        assign same     = probe.pc == code_break_address[g];
        assign invert   = code_break_control[g][debug_status_pkg::BREAK_INVERT];
        assign hit[g]   = probe.valid && break_on
            && per_thread_break_enables[probe.thread]
            && (same ^ invert);
    end

    always_comb begin
        lowest_hit = 2'd0;
        for (int i = debug_status_pkg::BREAK_N - 1; i >= 0; i--) begin
            if (hit[i]) begin
                lowest_hit = 2'(i);
            end
        end
    end

    assign any_hit = (|hit) && !debug_mode;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            break_request <= 1'b0;
            break_index   <= 2'd0;
            break_thread  <= 8'h00;
        end else begin
            break_request <= any_hit;
            if (any_hit) begin
                break_index  <= lowest_hit;
                break_thread <= {5'd0, probe.thread};
            end
        end
    end

    // ========================================================
    // Read path: data stand in the cycle after the strobe
    always_comb begin
        next_rd_data = debug_status_pkg::RESET_WORD;
        if (a[7:3] == debug_status_pkg::DEBUGGER_SCRATCH_IDX[7:3]) begin
            next_rd_data = debugger_scratch[a[2:0]];
        end else if (a[7:2]
                     == debug_status_pkg::CODE_BREAK_ADDRESS_IDX[7:2]) begin
            next_rd_data = code_break_address[a[1:0]];
        end else if (a[7:2]
                     == debug_status_pkg::CODE_BREAK_CONTROL_IDX[7:2]) begin
            next_rd_data = code_break_control[a[1:0]];
        end else begin
            unique case (a)
                debug_status_pkg::WIRE_RING_COUNT_IDX:
                    next_rd_data = {16'h0000, ring_count_value[0]};
                debug_status_pkg::PERIPH_CELL_RING_COUNT_IDX:
                    next_rd_data = {16'h0000, ring_count_value[1]};
                debug_status_pkg::PERIPH_WIRE_RING_COUNT_IDX:
                    next_rd_data = {16'h0000, ring_count_value[2]};
                debug_status_pkg::MEMORY_SIZE_IDX:
                    next_rd_data = {MEM_SIZE_BYTES[31:2], 2'b00};
                debug_status_pkg::SAVED_STATUS_WORD_IDX:
                    next_rd_data = saved_status_word;
                debug_status_pkg::SAVED_PROGRAM_COUNTER_IDX:
                    next_rd_data = saved_program_counter;
                debug_status_pkg::SAVED_STACK_POINTER_IDX:
                    next_rd_data = saved_stack_pointer;
                debug_status_pkg::REG_GET_THREAD_OPERAND_IDX:
                    next_rd_data = {24'h00_0000, target_thread_field};
                debug_status_pkg::REG_GET_INDEX_OPERAND_IDX:
                    next_rd_data = {27'h000_0000, target_register_field};
                debug_status_pkg::DEBUG_ENTRY_CAUSE_IDX:
                    next_rd_data = debug_entry_cause;
                debug_status_pkg::DEBUG_ENTRY_INFO_IDX:
                    next_rd_data = debug_entry_info;
                debug_status_pkg::THREAD_HALT_VECTOR_IDX:
                    next_rd_data = {24'h00_0000, halted_threads};
                default:
                    next_rd_data = debug_status_pkg::RESET_WORD;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= debug_status_pkg::RESET_WORD;
        end else if (reg_req.read) begin
            rd_data <= next_rd_data;
        end else begin
            rd_data <= debug_status_pkg::RESET_WORD;
        end
    end

endmodule // debug_breakpoint_status_regs

// file: design/debug_status_pkg.sv
// Purpose: Shared constants and carriers for the debug and status bank
// Assumes: Registers sit at their index on an 8-bit register address
// Notes:   Values here are referenced as debug_status_pkg::name
package debug_status_pkg;

    // ========================================================
    // Register indices
    localparam logic [7:0] WIRE_RING_COUNT_IDX        = 8'h08;
    localparam logic [7:0] PERIPH_CELL_RING_COUNT_IDX = 8'h09;
    localparam logic [7:0] PERIPH_WIRE_RING_COUNT_IDX = 8'h0a;
    localparam logic [7:0] MEMORY_SIZE_IDX            = 8'h0c;
    localparam logic [7:0] SAVED_STATUS_WORD_IDX      = 8'h10;
    localparam logic [7:0] SAVED_PROGRAM_COUNTER_IDX  = 8'h11;
    localparam logic [7:0] SAVED_STACK_POINTER_IDX    = 8'h12;
    localparam logic [7:0] REG_GET_THREAD_OPERAND_IDX = 8'h13;
    localparam logic [7:0] REG_GET_INDEX_OPERAND_IDX  = 8'h14;
    localparam logic [7:0] DEBUG_ENTRY_CAUSE_IDX      = 8'h15;
    localparam logic [7:0] DEBUG_ENTRY_INFO_IDX       = 8'h16;
    localparam logic [7:0] THREAD_HALT_VECTOR_IDX     = 8'h18;
    localparam logic [7:0] DEBUGGER_SCRATCH_IDX       = 8'h20;
    localparam logic [7:0] CODE_BREAK_ADDRESS_IDX     = 8'h30;
    localparam logic [7:0] CODE_BREAK_CONTROL_IDX     = 8'h40;

    // ========================================================
    // Sizes
    localparam int RING_W       = 16;
    localparam int SCRATCH_N    = 8;
    localparam int BREAK_N      = 4;
    localparam int THREAD_N     = 8;
    localparam int MEM_SIZE_LSB = 2;

    // ========================================================
    // Saved status word fields
    localparam int EVENT_ALLOW_FLAG     = 0;
    localparam int IRQ_ALLOW_FLAG       = 1;
    localparam int EVENT_SETUP_FLAG     = 2;
    localparam int IN_HANDLER_FLAG      = 3;
    localparam int KERNEL_MODE_FLAG     = 4;
    localparam int PAUSED_FLAG          = 6;
    localparam int CONTINUAL_ISSUE_FLAG = 7;
    localparam int DUAL_ISSUE_FLAG      = 8;
    localparam int ENTRY_ISSUE_FLAG     = 9;
    localparam int ADDRESS_SPACE_ID     = 10;
    localparam logic [31:0] STATUS_KEEP_MASK  = 32'h0000_07df;
    localparam logic [31:0] STATUS_WRITE_MASK = 32'h0000_06df;

    // ========================================================
    // Operand, cause and control fields
    localparam logic [31:0] TARGET_THREAD_MASK   = 32'h0000_00ff;
    localparam logic [31:0] TARGET_REGISTER_MASK = 32'h0000_001f;
    localparam logic [31:0] HALT_VECTOR_MASK     = 32'h0000_00ff;
    localparam logic [31:0] ENTRY_CAUSE_MASK     = 32'h0003_ff07;
    localparam logic [31:0] BREAK_CONTROL_MASK   = 32'h00ff_0003;
    localparam int CAUSE_LSB       = 0;
    localparam int CAUSE_THREAD_LSB = 8;
    localparam int CAUSE_INDEX_LSB = 16;
    localparam int BREAK_ON        = 0;
    localparam int BREAK_INVERT    = 1;
    localparam int BREAK_THREAD_LSB = 16;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    localparam logic [2:0] CAUSE_HOST      = 3'h1;
    localparam logic [2:0] CAUSE_CALL      = 3'h2;
    localparam logic [2:0] CAUSE_CODE_BRK  = 3'h3;
    localparam logic [2:0] CAUSE_DATA_WCH  = 3'h4;
    localparam logic [2:0] CAUSE_RSRC_WCH  = 3'h5;

    // ========================================================
    // Carriers
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        write;
        logic        read;
    } reg_req_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  cause;
        logic [7:0]  thread;
        logic [1:0]  index;
        logic [31:0] status;
        logic [31:0] pc;
        logic [31:0] sp;
        logic [31:0] info;
    } debug_entry_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  thread;
        logic [31:0] pc;
    } pc_probe_t;

endpackage

// file: testbench/debug_breakpoint_status_regs_chk.sv
// Purpose: Port assertions for the debug and status bank
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound into every instance of the bank
`timescale 1ns/1ps
module debug_breakpoint_status_regs_chk #(
    parameter logic [31:0] MEM_SIZE_BYTES = 32'h0004_0000
) (
    input wire logic                           clk,
    input wire logic                           rst_n,
    input wire debug_status_pkg::reg_req_t     reg_req,
    input wire logic [31:0]                    rd_data,
    input wire logic                           debug_mode,
    input wire debug_status_pkg::debug_entry_t entry,
    input wire debug_status_pkg::pc_probe_t    probe,
    input wire logic                           break_request,
    input wire logic [7:0]                     halted_threads,
    input wire logic [7:0]                     target_thread_field,
    input wire logic [4:0]                     target_register_field
);
    // ========================================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic       rd = reg_req.read;
    wire logic       wr = reg_req.write;
    wire logic [7:0] ad = reg_req.addr;
    logic [31:0]     last_pc;
    logic [31:0]     last_sp;
    logic            fresh;

    // Last captured context, valid until software overwrites it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {last_pc, last_sp, fresh} <= '0;
        end else if (entry.valid) begin
            {last_pc, last_sp, fresh} <= {entry.pc, entry.sp, 1'b1};
        end else if (wr && debug_mode && ad inside {8'h11, 8'h12}) begin
            fresh <= 1'b0;
        end
    end

    a_idle_read_zero: assert property (!rd |=> rd_data == 32'h0000_0000)
        else $error("read data not zero outside a read");
    a_ring_upper_zero: assert property (rd && ad inside {8'h08, 8'h09, 8'h0a}
        |=> rd_data[31:16] == 16'h0000) else $error("ring upper bits set");
    a_memory_size_value: assert property (rd && ad == 8'h0c
        |=> rd_data == {MEM_SIZE_BYTES[31:2], 2'b00})
        else $error("memory size wrong");
    a_status_reserved_zero: assert property (rd && ad == 8'h10
        |=> rd_data[31:11] == 21'h0 && !rd_data[5])
        else $error("status reserved bits set");
    a_entry_pc_capture: assert property (rd && ad == 8'h11 && fresh
        |=> rd_data == $past(last_pc))
        else $error("saved pc not captured");
    a_entry_sp_capture: assert property (rd && ad == 8'h12 && fresh
        |=> rd_data == $past(last_sp))
        else $error("saved sp not captured");
    a_thread_operand_read: assert property (rd && ad == 8'h13
        |=> rd_data == {24'h00_0000, target_thread_field})
        else $error("thread operand mismatch");
    a_index_operand_read: assert property (rd && ad == 8'h14
        |=> rd_data == {27'h000_0000, target_register_field})
        else $error("register operand mismatch");
    a_halt_write_taken: assert property (wr && debug_mode && ad == 8'h18
        |=> halted_threads == $past(reg_req.wdata[7:0]))
        else $error("halt vector not written");
    a_halt_write_refused: assert property (wr && !debug_mode && ad == 8'h18
        |=> $stable(halted_threads))
        else $error("halt vector written outside debug");
    a_break_quiet: assert property ((debug_mode || !probe.valid)
        |=> !break_request) else $error("break without probe");

    c_entry: cover property (entry.valid);
    c_break: cover property (break_request);
    c_debug_write: cover property (wr && debug_mode);
endmodule // debug_breakpoint_status_regs_chk

bind debug_breakpoint_status_regs debug_breakpoint_status_regs_chk #(
    .MEM_SIZE_BYTES(MEM_SIZE_BYTES)) chk (.clk, .rst_n, .reg_req, .rd_data,
    .debug_mode, .entry, .probe, .break_request, .halted_threads,
    .target_thread_field, .target_register_field);

// file: testbench/tb_debug_breakpoint_status_regs.sv
// Purpose: Register-level bench for the debug and status bank
// Assumes: Bank built with a memory size whose low bits are set
// Notes:   Break thread is read as the zero-extended thread number
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_debug_breakpoint_status_regs;
    logic                           clk, rst_n, debug_mode, cfg_write;
    debug_status_pkg::reg_req_t     reg_req;
    debug_status_pkg::debug_entry_t entry;
    debug_status_pkg::pc_probe_t    probe;
    logic [15:0]                    wire_ring_in, periph_cell_ring_in;
    logic [15:0]                    periph_wire_ring_in;
    logic [2:0]                     cfg_index;
    logic [31:0]                    cfg_wdata, cfg_rdata, rd_data, ie, ex;
    logic                           break_request;
    logic [1:0]                     break_index;
    logic [7:0]                     break_thread, halted_threads;
    logic [7:0]                     target_thread_field;
    logic [4:0]                     target_register_field;
    int                             failures, cmp_count, i;

    debug_breakpoint_status_regs #(.MEM_SIZE_BYTES(32'h0002_0003)) dut (
        .clk, .rst_n, .reg_req, .rd_data, .debug_mode, .entry, .probe,
        .wire_ring_in, .periph_cell_ring_in, .periph_wire_ring_in,
        .cfg_index, .cfg_wdata, .cfg_write, .cfg_rdata, .break_request,
        .break_index, .break_thread, .halted_threads, .target_thread_field,
        .target_register_field);

    // ========================================================
    // Bus and probe tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: w, write: 1'b1, read: 1'b0};
        @(posedge clk);
        reg_req <= '0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: 32'h0000_0000, write: 1'b0, read: 1'b1};
        @(posedge clk);
        reg_req <= '0;
        #1;
        `CHK(rd_data, e)
        @(posedge clk);
    endtask
    task automatic ent(input int c);
        @(posedge clk);
        entry <= '{valid: 1'b1, cause: 3'(c), thread: 8'h5a, index: 2'h3,
            status: 32'hffff_ffff, pc: 32'h1000_0000 + c,
            sp: 32'h2000_0000 + c, info: 32'h3000_0000 + c};
        @(posedge clk);
        entry <= '0;
    endtask
    task automatic pr(input logic [2:0] t, input logic [31:0] p,
                      input logic q, input logic [1:0] x);
        @(posedge clk);
        probe <= '{valid: 1'b1, thread: t, pc: p};
        @(posedge clk);
        probe <= '0;
        #1;
        `CHK(break_request, q)
        if (q) begin
            `CHK(break_index, x)
            `CHK(break_thread, {5'h00, t})
        end
        @(posedge clk);
    endtask
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic stop_test;
        $display("failures=%0d comparisons=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ========================================================
    // Clock, watchdog and tests
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        stop_test;
    end
    initial begin
        {reg_req, entry, probe, debug_mode, cfg_write} = '0;
        {cfg_index, cfg_wdata, failures, cmp_count} = '0;
        wire_ring_in = 16'h1234;
        periph_cell_ring_in = 16'hbeef;
        periph_wire_ring_in = 16'h00a5;
        rst_n = 1'b0;
        do_reset;
        for (i = 0; i < 4; i++) rc(8'h40 + i, 32'h0000_0000);
        rc(8'h15, 32'h0000_0000);
        repeat (12) @(posedge clk);
        rc(8'h08, 32'h0000_1234);
        rc(8'h09, 32'h0000_beef);
        rc(8'h0a, 32'h0000_00a5);
        rc(8'h0c, 32'h0002_0000);
        rc(8'h0b, 32'h0000_0000);
        wr(8'h18, 32'hffff_ff05);
        rc(8'h18, 32'h0000_0000);
        debug_mode <= 1'b1;
        wr(8'h18, 32'hffff_ff05);
        rc(8'h18, 32'h0000_0005);
        `CHK(halted_threads, 8'h05)
        wr(8'h10, 32'hffff_ffff);
        rc(8'h10, 32'h0000_06df);
        wr(8'h13, 32'hffff_ffff);
        rc(8'h13, 32'h0000_00ff);
        `CHK(target_thread_field, 8'hff)
        wr(8'h14, 32'hffff_ffff);
        rc(8'h14, 32'h0000_001f);
        `CHK(target_register_field, 5'h1f)
        wr(8'h11, 32'hcafe_0001);
        rc(8'h11, 32'hcafe_0001);
        ie = 32'h0000_0000;
        for (i = 1; i <= 5; i++) begin
            ent(i);
            if (i >= 4) ie = 32'h3000_0000 + i;
            ex = {14'h0, (i > 2) ? 2'h3 : 2'h0, (i == 1) ? 8'h00 : 8'h5a,
                  5'h00, 3'(i)};
            rc(8'h15, ex);
            rc(8'h16, ie);
            rc(8'h11, 32'h1000_0000 + i);
            rc(8'h12, 32'h2000_0000 + i);
            rc(8'h10, 32'h0000_07df);
        end
        for (i = 0; i < 8; i++) wr(8'h20 + i, 32'h5c00_0000 + i);
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            cfg_index <= 3'(i);
            @(posedge clk);
            #1;
            `CHK(cfg_rdata, 32'h5c00_0000 + i)
        end
        @(posedge clk);
        {cfg_index, cfg_wdata, cfg_write} <= {3'h7, 32'h0c0f_fee7, 1'b1};
        @(posedge clk);
        cfg_write <= 1'b0;
        rc(8'h27, 32'h0c0f_fee7);
        wr(8'h30, 32'h0000_1000);
        wr(8'h40, 32'h0004_0001);
        wr(8'h31, 32'h0000_2000);
        wr(8'h41, 32'hffff_ffff);
        rc(8'h41, 32'h00ff_0003);
        wr(8'h41, 32'h0004_0003);
        pr(3'h2, 32'h0000_1000, 1'b0, 2'h0);
        debug_mode <= 1'b0;
        pr(3'h2, 32'h0000_1000, 1'b1, 2'h0);
        pr(3'h2, 32'h0000_1004, 1'b1, 2'h1);
        pr(3'h3, 32'h0000_1000, 1'b0, 2'h0);
        wr(8'h41, 32'h0000_0000);
        pr(3'h2, 32'h0000_1004, 1'b1, 2'h1);
        debug_mode <= 1'b1;
        wr(8'h40, 32'h0004_0000);
        debug_mode <= 1'b0;
        pr(3'h2, 32'h0000_1000, 1'b1, 2'h1);
        do_reset;
        rc(8'h08, 32'h0000_1234);
        rc(8'h10, 32'h0000_0000);
        `CHK(halted_threads, 8'h00)
        stop_test;
    end
endmodule // tb_debug_breakpoint_status_regs
